/* File: design/sirt_pkg.sv */
package sirt_pkg;

  // clock rate and the 0.1 ms retry tick
  localparam int CLK_MHZ = 20;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TICK_CW = $clog2(TICK_CYCLES);
  localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_CYCLES - 1);

  // bit positions shared by the command byte and the event flags
  localparam int BIT_EXPIRY = 0;
  localparam int BIT_UNSOL_ADVERT = 1;
  localparam int BIT_ROUTER_QUERY = 2;
  localparam int BIT_DUP_PROBE = 3;
  localparam int BIT_V6_ECHO = 4;
  localparam int BIT_V6_RESOLVE = 5;
  localparam int BIT_V4_ECHO = 6;
  localparam int BIT_V4_RESOLVE = 7;

  // socket event flag bit raised by a tcp timeout
  localparam int SOCK_EXPIRY_BIT = 3;

  // socket commands that can end in a tcp timeout
  localparam logic [7:0] SOCK_CONNECT = 8'h04;
  localparam logic [7:0] SOCK_IPV6_CONNECT = 8'h84;
  localparam logic [7:0] SOCK_SEND = 8'h20;
  localparam logic [7:0] SOCK_IPV6_SEND = 8'ha0;
  localparam logic [7:0] SOCK_DISCONNECT = 8'h08;

  // fixed multicast destinations
  localparam logic [127:0] ALL_ROUTERS = 128'hff02_0000_0000_0000_0000_0000_0000_0002;
  localparam logic [127:0] ALL_NODES = 128'hff02_0000_0000_0000_0000_0000_0000_0001;

  // router advertisement option types the capture depends on
  localparam logic [7:0] OPT_SRC_LINK = 8'h01;
  localparam logic [7:0] OPT_PREFIX = 8'h03;

  // prefix select bit: 0 link-local, 1 global unicast
  localparam int PSEL_GLOBAL_BIT = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_TXW = 4'b0100,
    ST_RESP = 4'b1000
  } sirt_state_t;

  typedef enum logic [2:0] {
    PK_NONE = 3'h0,
    PK_V4_RESOLVE = 3'h1,
    PK_V4_ECHO = 3'h2,
    PK_NBR_SOLICIT = 3'h3,
    PK_DUP_SOLICIT = 3'h4,
    PK_ROUTER_SOLICIT = 3'h5,
    PK_UNSOL_ADVERT = 3'h6,
    PK_V6_ECHO = 3'h7
  } sirt_pkt_t;

  typedef enum logic [2:0] {
    RX_NONE = 3'h0,
    RX_V4_REPLY = 3'h1,
    RX_V4_ECHO = 3'h2,
    RX_NBR_ADVERT = 3'h3,
    RX_DUP_ADVERT = 3'h4,
    RX_ROUTER_ADVERT = 3'h5,
    RX_V6_ECHO = 3'h6
  } sirt_rx_t;

  typedef struct packed {
    sirt_pkt_t kind;
    logic [127:0] dest;
    logic [127:0] target;
  } sirt_tx_t;

  typedef struct packed {
    logic [7:0] prefix_len;
    logic [7:0] flags;
    logic [31:0] valid_lt;
    logic [31:0] pref_lt;
    logic [127:0] prefix;
  } sirt_ra_t;

endpackage

/* File: design/sirt_retry_timer.sv */
`timescale 1ns/1ns
module sirt_retry_timer
  import sirt_pkg::*;
#(
  parameter int IVL_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic backoff,
  input wire logic [IVL_W-1:0] interval,
  // one-cycle pulse per elapsed interval
  output logic expired
);

  logic run_q;
  logic [TICK_CW-1:0] tick_q;
  logic [IVL_W-1:0] ivl_q;
  logic [IVL_W-1:0] cur_q;
  logic tick_end;
  logic ivl_end;

  assign tick_end = run_q && (tick_q == TICK_LAST);
  // a zero interval expires on every tick rather than never
  assign ivl_end = tick_end && ((ivl_q + 1'b1) >= cur_q);

  // running state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
    end else if (stop) begin
      run_q <= 1'b0;
    end
  end

  // 0.1 ms prescaler
  always_ff @(posedge sys_clk) begin
    if (!rst_n || start || !run_q || tick_end) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // ticks within the current interval
  always_ff @(posedge sys_clk) begin
    if (!rst_n || start || ivl_end) begin
      ivl_q <= '0;
    end else if (tick_end) begin
      ivl_q <= ivl_q + 1'b1;
    end
  end

  // interval doubles while the doubled value still fits, then holds
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else if (start) begin
      cur_q <= interval;
    end else if (ivl_end && backoff && !cur_q[IVL_W-1]) begin
      cur_q <= {cur_q[IVL_W-2:0], 1'b0};
    end
  end

  // expiry pulse, suppressed when the wait is being torn down
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= ivl_end && !stop && !start;
    end
  end

endmodule

/* File: design/sirt_flag_bank.sv */
`timescale 1ns/1ns
module sirt_flag_bank
  import sirt_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // hardware sets, software clears by writing one
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] mask,
  // state
  output logic [W-1:0] flags,
  output logic irq
);

  // a set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags <= W'(RST_BYTE);
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

  // only unmasked flags reach the interrupt line
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end

endmodule

/* File: design/sirt_engine.sv */
`timescale 1ns/1ns
// Functional notes
// - duplicate probe command sends a detection solicitation to the ipv6 target.
// - detection advert answering the probe sets the probe flag; address unusable.
// - no answer before retries run out sets the expiry flag; address usable.
// - router query command sends a solicitation to the all-routers group.
// - router advert sets router-query flag and stores the prefix data.
// - no router advert before retries run out sets the expiry flag.
// - prefix data is only valid with source-link then prefix options.
// - unsolicited advert goes to all-nodes, target chosen by prefix select.
// - unsolicited advert sets the expiry flag once it has been sent.
// - command byte returns to zero on acceptance; host polls for zero.
// - resolve, echo and discovery requests are resent each interval until answered.
// - timeout once retransmissions exceed the programmed retry count.
// - interval unit is 0.1 ms; total wait is interval times count plus one.
// - discovery timeouts from resolve, probe or query set the expiry flag.
// - echo commands also time out when resolution works but no reply comes.
// - tcp segment resent each socket interval until acked, times out past limit.
// - tcp interval doubles per retry until doubling would pass 65535, then holds.
// - connect, send and disconnect timeouts set the socket timeout flag.
module sirt_engine
  import sirt_pkg::*;
#(
  parameter int IVL_W = 16,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host command, clear and mask ports
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] sockless_flag_clear,
  input wire logic [7:0] sockless_irq_mask,
  // socket-less configuration
  input wire logic [IVL_W-1:0] sockless_retry_interval,
  input wire logic [CNT_W-1:0] sockless_retry_limit,
  input wire logic [127:0] ipv6_target_address,
  input wire logic [31:0] target_address,
  input wire logic [7:0] prefix_select,
  input wire logic [127:0] link_local_address,
  input wire logic [127:0] global_unicast_address,
  // transmit path
  output sirt_tx_t tx_pkt,
  output logic tx_req,
  input wire logic tx_done,
  // receive path
  input wire logic rx_valid,
  input wire sirt_rx_t rx_kind,
  input wire logic [7:0] rx_opt1,
  input wire logic [7:0] rx_opt2,
  input wire sirt_ra_t rx_ra,
  // socket-less status
  output logic [7:0] sockless_command_reg,
  output logic [7:0] sockless_event_flags,
  output logic sockless_irq,
  // router advertisement results
  output logic [7:0] prefix_length_store,
  output logic [7:0] router_flags_store,
  output logic [7:0] router_flags_copy,
  output logic [31:0] valid_lifetime_store,
  output logic [31:0] prefix_lifetime_store,
  output logic [127:0] prefix_address_store,
  // tcp socket side
  input wire logic sock_cmd_wr,
  input wire logic [7:0] sock_cmd_wdata,
  input wire logic [IVL_W-1:0] socket_retry_interval,
  input wire logic [CNT_W-1:0] socket_retry_limit,
  input wire logic sock_seg_sent,
  input wire logic sock_ack_rx,
  input wire logic [7:0] socket_flag_clear,
  input wire logic [7:0] socket_irq_mask,
  output logic [7:0] socket_command_reg,
  output logic [7:0] socket_event_flags,
  output logic socket_irq,
  output logic sock_retx_req
);

  sirt_state_t state_q;
  sirt_state_t state_d;
  logic [7:0] cmd_q;
  logic [7:0] op_q;
  logic [7:0] op_pick;
  logic phase_q;
  logic [CNT_W-1:0] retry_q;
  logic tx_req_q;
  sirt_tx_t tx_q;
  sirt_tx_t tx_d;
  sirt_ra_t ra_q;
  logic [7:0] sl_set;
  logic sl_start;
  logic sl_stop;
  logic sl_exp;
  logic resp_hit;
  logic resp_mid;
  logic retries_done;

  logic [7:0] sock_cmd_q;
  logic [7:0] tcp_cmd_q;
  logic tcp_wait_q;
  logic [CNT_W-1:0] tcp_retry_q;
  logic tcp_armed;
  logic tcp_exp;
  logic tcp_to;
  logic retx_q;
  logic [7:0] sock_set;

  // lowest pending command bit wins if software sets several at once
  always_comb begin
    op_pick = '0;
    for (int i = 7; i >= 1; i--) begin
      if (cmd_q[i]) begin
        op_pick = '0;
        op_pick[i] = 1'b1;
      end
    end
  end

  // answer matching: resp_mid ends the resolve phase of an echo command
  always_comb begin
    resp_hit = 1'b0;
    resp_mid = 1'b0;
    if (rx_valid) begin
      if (op_q[BIT_DUP_PROBE] && rx_kind == RX_DUP_ADVERT) begin
        resp_hit = 1'b1;
      end else if (op_q[BIT_ROUTER_QUERY] && rx_kind == RX_ROUTER_ADVERT) begin
        resp_hit = 1'b1;
      end else if (op_q[BIT_V6_RESOLVE] && rx_kind == RX_NBR_ADVERT) begin
        resp_hit = 1'b1;
      end else if (op_q[BIT_V4_RESOLVE] && rx_kind == RX_V4_REPLY) begin
        resp_hit = 1'b1;
      end else if (op_q[BIT_V6_ECHO]) begin
        resp_mid = !phase_q && rx_kind == RX_NBR_ADVERT;
        resp_hit = phase_q && rx_kind == RX_V6_ECHO;
      end else if (op_q[BIT_V4_ECHO]) begin
        resp_mid = !phase_q && rx_kind == RX_V4_REPLY;
        resp_hit = phase_q && rx_kind == RX_V4_ECHO;
      end
    end
  end

  // timeout once the retries already sent reach the limit, i.e. the next would exceed it
  assign retries_done = (retry_q == sockless_retry_limit);

  // packet description for the current command and phase
  always_comb begin
    tx_d = '0;
    tx_d.dest = ipv6_target_address;
    if (op_q[BIT_DUP_PROBE]) begin
      tx_d.kind = PK_DUP_SOLICIT;
      tx_d.target = ipv6_target_address;
    end else if (op_q[BIT_ROUTER_QUERY]) begin
      tx_d.kind = PK_ROUTER_SOLICIT;
      tx_d.dest = ALL_ROUTERS;
    end else if (op_q[BIT_UNSOL_ADVERT]) begin
      tx_d.kind = PK_UNSOL_ADVERT;
      tx_d.dest = ALL_NODES;
      tx_d.target = prefix_select[PSEL_GLOBAL_BIT] ? global_unicast_address
                                                   : link_local_address;
    end else if (op_q[BIT_V6_RESOLVE]) begin
      tx_d.kind = PK_NBR_SOLICIT;
      tx_d.target = ipv6_target_address;
    end else if (op_q[BIT_V6_ECHO]) begin
      tx_d.kind = phase_q ? PK_V6_ECHO : PK_NBR_SOLICIT;
      tx_d.target = ipv6_target_address;
    end else if (op_q[BIT_V4_RESOLVE] || op_q[BIT_V4_ECHO]) begin
      tx_d.kind = (op_q[BIT_V4_ECHO] && phase_q) ? PK_V4_ECHO : PK_V4_RESOLVE;
      tx_d.dest = {96'h0, target_address};
      tx_d.target = {96'h0, target_address};
    end
  end

  // command sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_q != RST_BYTE && op_pick != RST_BYTE) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        state_d = ST_TXW;
      end
      ST_TXW: begin
        if (tx_done) begin
          state_d = op_q[BIT_UNSOL_ADVERT] ? ST_IDLE : ST_RESP;
        end
      end
      ST_RESP: begin
        if (resp_hit) begin
          state_d = ST_IDLE;
        end else if (resp_mid) begin
          state_d = ST_SEND;
        end else if (sl_exp) begin
          state_d = retries_done ? ST_IDLE : ST_SEND;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command byte: a fresh write wins over the clear on acceptance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_q <= RST_BYTE;
    end else if (cmd_wr) begin
      cmd_q <= cmd_wdata;
    end else if (state_q == ST_IDLE && cmd_q != RST_BYTE) begin
      cmd_q <= RST_BYTE;
    end
  end

  // accepted command, phase and retry count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_q <= RST_BYTE;
      phase_q <= 1'b0;
      retry_q <= '0;
    end else if (state_q == ST_IDLE) begin
      if (cmd_q != RST_BYTE) begin
        op_q <= op_pick;
        phase_q <= 1'b0;
        retry_q <= '0;
      end
    end else if (state_q == ST_RESP) begin
      if (resp_mid) begin
        phase_q <= 1'b1;
      end else if (sl_exp && !retries_done) begin
        retry_q <= retry_q + 1'b1;
      end
    end
  end

  // transmit request holds until the link reports the packet sent
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_req_q <= 1'b0;
      tx_q <= '0;
    end else if (state_q == ST_SEND) begin
      tx_req_q <= 1'b1;
      tx_q <= tx_d;
    end else if (state_q == ST_TXW && tx_done) begin
      tx_req_q <= 1'b0;
    end
  end

  // the wait timer restarts after every send, so each attempt gets a full interval
  assign sl_start = (state_q == ST_TXW) && tx_done && !op_q[BIT_UNSOL_ADVERT];
  assign sl_stop = (state_q != ST_RESP) || (state_d != ST_RESP);

  sirt_retry_timer #(
    .IVL_W(IVL_W)
  ) u_sl_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(sl_start),
    .stop(sl_stop),
    .backoff(1'b0),
    .interval(sockless_retry_interval),
    .expired(sl_exp)
  );

  // event flag sets
  always_comb begin
    sl_set = '0;
    if (state_q == ST_TXW && tx_done && op_q[BIT_UNSOL_ADVERT]) begin
      sl_set[BIT_EXPIRY] = 1'b1;
    end
    if (state_q == ST_RESP && resp_hit) begin
      sl_set = op_q;
    end else if (state_q == ST_RESP && !resp_mid && sl_exp && retries_done) begin
      sl_set[BIT_EXPIRY] = 1'b1;
    end
  end

  sirt_flag_bank #(
    .W(8)
  ) u_sl_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set(sl_set),
    .clr(sockless_flag_clear),
    .mask(sockless_irq_mask),
    .flags(sockless_event_flags),
    .irq(sockless_irq)
  );

  // prefix capture only for the option layout the parser understands
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ra_q <= '0;
    end else if (state_q == ST_RESP && resp_hit && op_q[BIT_ROUTER_QUERY] &&
                 rx_opt1 == OPT_SRC_LINK && rx_opt2 == OPT_PREFIX) begin
      ra_q <= rx_ra;
    end
  end

  // socket command byte clears the cycle after it is written
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sock_cmd_q <= RST_BYTE;
      tcp_cmd_q <= RST_BYTE;
    end else if (sock_cmd_wr) begin
      sock_cmd_q <= sock_cmd_wdata;
    end else if (sock_cmd_q != RST_BYTE) begin
      tcp_cmd_q <= sock_cmd_q;
      sock_cmd_q <= RST_BYTE;
    end
  end

  // only these commands put a segment under retransmission watch
  assign tcp_armed = (tcp_cmd_q == SOCK_CONNECT) || (tcp_cmd_q == SOCK_IPV6_CONNECT) ||
                     (tcp_cmd_q == SOCK_SEND) || (tcp_cmd_q == SOCK_IPV6_SEND) ||
                     (tcp_cmd_q == SOCK_DISCONNECT);
  assign tcp_to = tcp_wait_q && tcp_exp && !sock_ack_rx &&
                  (tcp_retry_q == socket_retry_limit);

  // tcp wait: the timer keeps running across retries so the backoff accumulates
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tcp_wait_q <= 1'b0;
      tcp_retry_q <= '0;
      retx_q <= 1'b0;
    end else begin
      retx_q <= 1'b0;
      if (sock_seg_sent && tcp_armed) begin
        tcp_wait_q <= 1'b1;
        tcp_retry_q <= '0;
      end else if (sock_ack_rx || tcp_to) begin
        tcp_wait_q <= 1'b0;
      end else if (tcp_wait_q && tcp_exp) begin
        tcp_retry_q <= tcp_retry_q + 1'b1;
        retx_q <= 1'b1;
      end
    end
  end

  sirt_retry_timer #(
    .IVL_W(IVL_W)
  ) u_tcp_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(sock_seg_sent && tcp_armed),
    .stop(sock_ack_rx || tcp_to),
    .backoff(1'b1),
    .interval(socket_retry_interval),
    .expired(tcp_exp)
  );

  always_comb begin
    sock_set = '0;
    sock_set[SOCK_EXPIRY_BIT] = tcp_to;
  end

  sirt_flag_bank #(
    .W(8)
  ) u_sock_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set(sock_set),
    .clr(socket_flag_clear),
    .mask(socket_irq_mask),
    .flags(socket_event_flags),
    .irq(socket_irq)
  );

  // outputs straight from registers
  assign tx_req = tx_req_q;
  assign tx_pkt = tx_q;
  assign sockless_command_reg = cmd_q;
  assign socket_command_reg = sock_cmd_q;
  assign sock_retx_req = retx_q;
  assign prefix_length_store = ra_q.prefix_len;
  assign router_flags_store = ra_q.flags;
  assign router_flags_copy = ra_q.flags;
  assign valid_lifetime_store = ra_q.valid_lt;
  assign prefix_lifetime_store = ra_q.pref_lt;
  assign prefix_address_store = ra_q.prefix;

endmodule

/* File: verification/sirt_engine_assertions.sv */
`timescale 1ns/1ns
// watches engine pins only
module sirt_engine_assertions
  import sirt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // host side
  input wire logic [7:0] sockless_irq_mask,
  input wire logic [7:0] prefix_select,
  input wire logic [127:0] ipv6_target_address,
  input wire logic [127:0] link_local_address,
  input wire logic [127:0] global_unicast_address,
  input wire logic [7:0] sockless_command_reg,
  input wire logic [7:0] sockless_event_flags,
  input wire logic sockless_irq,
  // link side
  input wire sirt_tx_t tx_pkt,
  input wire logic tx_req,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire sirt_rx_t rx_kind,
  input wire logic [7:0] rx_opt1,
  input wire logic [7:0] rx_opt2,
  input wire sirt_ra_t rx_ra,
  // results and tcp
  input wire logic [7:0] prefix_length_store,
  input wire logic [127:0] prefix_address_store,
  input wire logic sock_retx_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // router data trusted only with source-link then prefix options
  wire ra_rx = rx_valid && rx_kind == RX_ROUTER_ADVERT;
  wire opt_ok = rx_opt1 == OPT_SRC_LINK && rx_opt2 == OPT_PREFIX;
  wire [2:0] kind = tx_req ? tx_pkt.kind : 3'h0;

  accept_send_a: assert property ($fell(|sockless_command_reg) |-> ##[1:2] tx_req)
    else $error("no send after accept");
  probe_target_a: assert property (kind == PK_DUP_SOLICIT |-> tx_pkt.target == ipv6_target_address)
    else $error("probe target wrong");
  query_dest_a: assert property (kind == PK_ROUTER_SOLICIT |-> tx_pkt.dest == ALL_ROUTERS)
    else $error("query destination wrong");
  advert_addr_a: assert property (kind == PK_UNSOL_ADVERT |-> tx_pkt.dest == ALL_NODES &&
    tx_pkt.target == (prefix_select[PSEL_GLOBAL_BIT] ? global_unicast_address : link_local_address))
    else $error("advert addresses wrong");
  advert_expiry_a: assert property (kind == PK_UNSOL_ADVERT && tx_done |=> sockless_event_flags[0])
    else $error("advert without expiry");
  tx_hold_a: assert property (tx_req && !tx_done |=> tx_req && $stable(tx_pkt))
    else $error("request dropped");
  irq_mask_a: assert property (sockless_irq == |$past(sockless_event_flags & sockless_irq_mask))
    else $error("irq not masked flags");
  ra_store_a: assert property (ra_rx && opt_ok |=> prefix_address_store == $past(rx_ra.prefix) &&
    prefix_length_store == $past(rx_ra.prefix_len))
    else $error("router data not stored");
  ra_skip_a: assert property (ra_rx && !opt_ok |=> $stable(prefix_address_store))
    else $error("odd options changed stores");
  retx_pulse_a: assert property (sock_retx_req |=> !sock_retx_req ##1 !sock_retx_req)
    else $error("resend pulse too long");
endmodule

bind sirt_engine sirt_engine_assertions sirt_engine_assertions_i (.*);

/* File: verification/sirt_peer.sv */
`timescale 1ns/1ns
// neighbour: ends each frame, answers kinds set in ans_en
module sirt_peer
  import sirt_pkg::*;
(
  // clock and bench controls
  input wire logic sys_clk,
  input wire logic [7:0] ans_en,
  input wire logic [7:0] opt1_in,
  input wire logic [7:0] opt2_in,
  input wire sirt_ra_t ra_in,
  // engine link side
  input wire sirt_tx_t tx_pkt,
  input wire logic tx_req,
  output logic tx_done = 1'b0,
  output logic rx_valid = 1'b0,
  output sirt_rx_t rx_kind = RX_NONE,
  output logic [7:0] rx_opt1 = 8'h00,
  output logic [7:0] rx_opt2 = 8'h00,
  output sirt_ra_t rx_ra = '0
);
  sirt_rx_t reply;
  // one frame at a time; released rx_opt1 and rx_ra show inverted values, rx_opt2 holds its value
  always begin
    @(posedge sys_clk);
    #1;
    if (tx_req === 1'b1) begin
      reply = tx_pkt.kind == PK_V6_ECHO ? RX_V6_ECHO : sirt_rx_t'(tx_pkt.kind);
      repeat (3) @(posedge sys_clk);
      #5 tx_done = 1'b1;
      @(posedge sys_clk);
      #5 tx_done = 1'b0;
      if (tx_pkt.kind != PK_UNSOL_ADVERT && ans_en[reply]) begin
        repeat (4) @(posedge sys_clk);
        #5 rx_valid = 1'b1;
        rx_kind = reply;
        rx_opt1 = opt1_in;
        rx_opt2 = opt2_in;
        rx_ra = ra_in;
        @(posedge sys_clk);
        #5 rx_valid = 1'b0;
        rx_kind = RX_NONE;
        rx_opt1 = ~rx_opt1;
        rx_ra = ~rx_ra;
      end
    end
  end
endmodule

/* File: verification/sirt_engine_bench.sv */
`timescale 1ns/1ns
// host tasks on the ports, neighbour model on the link
module sirt_engine_bench
  import sirt_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, sock_cmd_wr = 1'b0;
  logic sock_seg_sent = 1'b0, sock_ack_rx = 1'b0, tx_q = 1'b0;
  logic [7:0] cmd_wdata = 8'h00, sockless_flag_clear = 8'h00, sockless_irq_mask = 8'h00;
  logic [7:0] sock_cmd_wdata = 8'h00, socket_flag_clear = 8'h00, socket_irq_mask = 8'h00;
  logic [7:0] sockless_retry_limit = 8'h00, socket_retry_limit = 8'h00, prefix_select = 8'h00;
  logic [15:0] sockless_retry_interval = 16'h0001, socket_retry_interval = 16'h0001;
  logic [127:0] ipv6_target_address = 128'hfe800000000000000000000000000a01;
  logic [127:0] link_local_address = 128'hfe800000000000000000000000000b02;
  logic [127:0] global_unicast_address = 128'h20010db8000000000000000000000c03;
  logic [31:0] target_address = 32'hc0a8_0064;
  logic [7:0] ans_en = 8'h00, opt1_in = OPT_SRC_LINK, opt2_in = OPT_PREFIX;
  sirt_ra_t ra_in = '0, rx_ra;
  sirt_tx_t tx_pkt, last_pkt;
  sirt_rx_t rx_kind;
  logic tx_req, tx_done, rx_valid, sockless_irq, socket_irq, sock_retx_req;
  logic [7:0] rx_opt1, rx_opt2, sockless_command_reg, sockless_event_flags, prefix_length_store;
  logic [7:0] router_flags_store, router_flags_copy, socket_command_reg, socket_event_flags;
  logic [31:0] valid_lifetime_store, prefix_lifetime_store;
  logic [127:0] prefix_address_store;
  int error_cnt = 0, checks = 0, tx_cnt = 0, cyc = 0;

  sirt_engine sirt_engine_i (.*);
  sirt_peer sirt_peer_i (.*);

  always #25 sys_clk = ~sys_clk;
  // count frames, keep each first beat, cut a hang short
  always @(posedge sys_clk) begin
    tx_q <= tx_req;
    cyc++;
    if (tx_req && !tx_q) begin
      tx_cnt++;
      last_pkt <= tx_pkt;
    end
    if (cyc == 80000) begin
      error_cnt++;
      $display("ERROR cycles expected <80000 seen 80000");
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // write, check zero two cycles on, wait for flag fb
  task automatic run(input logic [7:0] c, input int fb, input int lim, output int n);
    n = 0;
    tx_cnt = 0;
    cmd_wdata = c;
    cmd_wr = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    tick(2);
    chk("cmd byte", 8'h00, sockless_command_reg);
    while (sockless_event_flags[fb] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk("flag byte", 8'h01 << fb, sockless_event_flags);
  endtask

  // clear all socket-less flags
  task automatic clr_all();
    sockless_flag_clear = 8'hff;
    tick(1);
    sockless_flag_clear = 8'h00;
    tick(1);
    chk("flags cleared", 8'h00, sockless_event_flags);
  endtask

  // all kinds answered; echoes take two frames
  task automatic t_answered();
    int n;
    ans_en = 8'hff;
    sockless_retry_limit = 8'h03;
    for (int b = 2; b < 8; b++) begin
      run(8'h01 << b, b, 4000, n);
      chk("frames", (b == 4 || b == 6) ? 2 : 1, tx_cnt);
      clr_all();
    end
  endtask

  // prefix data stored; odd option order keeps it
  task automatic t_router();
    int n;
    ra_in = {8'h40, 8'hc0, 32'h0001_5180, 32'h0000_3840, global_unicast_address};
    run(8'h04, BIT_ROUTER_QUERY, 4000, n);
    chk("length", 8'h40, prefix_length_store);
    chk("flags", 16'hc0c0, {router_flags_store, router_flags_copy});
    chk("lifetimes", 64'h0001_5180_0000_3840, {valid_lifetime_store, prefix_lifetime_store});
    chk("prefix", global_unicast_address, prefix_address_store);
    chk("query dest", ALL_ROUTERS, last_pkt.dest);
    clr_all();
    opt1_in = OPT_PREFIX;
    ra_in = '1;
    run(8'h04, BIT_ROUTER_QUERY, 4000, n);
    chk("prefix kept", global_unicast_address, prefix_address_store);
    opt1_in = OPT_SRC_LINK;
    clr_all();
  endtask

  // no answer: expiry after lim+1 sends
  task automatic t_silent(input logic [7:0] c, input int lim);
    int n;
    ans_en = 8'h00;
    sockless_retry_limit = lim[7:0];
    run(c, BIT_EXPIRY, 20000, n);
    chk("sends", lim + 1, tx_cnt);
    chk("wait", 1, n > (lim + 1) * TICK_CYCLES - 10 && n < (lim + 1) * (TICK_CYCLES + 20));
    clr_all();
  endtask

  // advert with both targets; irq only when unmasked
  task automatic t_advert();
    int n;
    for (int s = 0; s < 2; s++) begin
      prefix_select = 8'h10 | s[7:0];
      run(8'h02, BIT_EXPIRY, 40, n);
      chk("advert quick", 1, n < 10);
      chk("advert dest", ALL_NODES, last_pkt.dest);
      chk("target", s ? global_unicast_address : link_local_address, last_pkt.target);
      chk("irq masked", 1'b0, sockless_irq);
      sockless_irq_mask = 8'h01;
      tick(2);
      chk("irq raised", 1'b1, sockless_irq);
      sockless_irq_mask = 8'h00;
      clr_all();
    end
  endtask

  // segment waits a cycle so the command is latched first; r: first resend
  task automatic tcp_run(input logic [7:0] c, output int n, output int r);
    n = 0;
    r = 0;
    sock_cmd_wdata = c;
    sock_cmd_wr = 1'b1;
    tick(1);
    sock_cmd_wr = 1'b0;
    tick(1);
    sock_seg_sent = 1'b1;
    tick(1);
    sock_seg_sent = 1'b0;
    while (socket_event_flags[SOCK_EXPIRY_BIT] !== 1'b1 && n < 20000) begin
      if (sock_retx_req === 1'b1 && r == 0) r = n;
      tick(1);
      n++;
    end
    chk("socket flags", 8'h01 << SOCK_EXPIRY_BIT, socket_event_flags);
    socket_flag_clear = 8'hff;
    tick(1);
    socket_flag_clear = 8'h00;
  endtask

  // every timeout command, then a 1, 2, 4 tick backoff
  task automatic t_tcp();
    logic [7:0] codes [5] = '{SOCK_CONNECT, SOCK_IPV6_CONNECT, SOCK_SEND, SOCK_IPV6_SEND,
      SOCK_DISCONNECT};
    int n, r;
    for (int i = 0; i < 5; i++) begin
      tcp_run(codes[i], n, r);
      chk("tcp one", 1, n > TICK_CYCLES - 10 && n < TICK_CYCLES + 30);
    end
    socket_retry_limit = 8'h02;
    tcp_run(SOCK_SEND, n, r);
    chk("first resend", 1, r > TICK_CYCLES - 10 && r < TICK_CYCLES + 30);
    chk("backoff", 1, n > 7 * TICK_CYCLES - 10 && n < 7 * TICK_CYCLES + 60);
  endtask

  task automatic results();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    int n;
    tick(8);
    rst_n = 1'b1;
    tick(1);
    chk("reset", 8'h00, sockless_event_flags | sockless_command_reg);
    t_answered();
    t_router();
    t_silent(8'h08, 2);
    t_silent(8'h04, 0);
    ans_en = 8'h08;
    sockless_retry_limit = 8'h01;
    run(8'h10, BIT_EXPIRY, 20000, n);
    clr_all();
    t_advert();
    t_tcp();
    results();
  end
endmodule
